// >>> rtl/ssx_regs.svh
// Register offsets, field positions and reset values of the datapath slice
`ifndef SSX_REGS_SVH
`define SSX_REGS_SVH

// APB byte offsets
`define SSX_ADDR_W        12
`define SSX_OFF_CMD       12'h000
`define SSX_OFF_WORK      12'h004
`define SSX_OFF_STATUS    12'h008
`define SSX_OFF_DIR1      12'h00c
`define SSX_OFF_DIR2      12'h010
`define SSX_OFF_DIR3      12'h014
`define SSX_FILE_TAG      3'h1
`define SSX_FILE_TAG_HI   11
`define SSX_FILE_TAG_LO   9
`define SSX_FILE_IDX_HI   8
`define SSX_FILE_IDX_LO   2

// Command register fields
`define SSX_CMD_OP_HI     2
`define SSX_CMD_OP_LO     0
`define SSX_CMD_DEST      3
`define SSX_CMD_FILE_HI   10
`define SSX_CMD_FILE_LO   4
`define SSX_CMD_LIT_HI    23
`define SSX_CMD_LIT_LO    16

// Status register fields
`define SSX_ST_CARRY      0
`define SSX_ST_DIGIT      1
`define SSX_ST_ZERO       2

// Direction-load operands and reset values
`define SSX_DIR_OP1       7'h05
`define SSX_DIR_OP2       7'h06
`define SSX_DIR_OP3       7'h07
`define SSX_DIR_RESET     8'hff
`define SSX_DEST_FILE     1'b1

`endif

// >>> rtl/ssx_pkg.sv
// Types shared by the datapath slice
package ssx_pkg;

  // Instruction selector, taken from the command register op field
  typedef enum logic [2:0] {
    SSX_OP_SUBB,
    SSX_OP_SWAP,
    SSX_OP_DIR,
    SSX_OP_XORI,
    SSX_OP_XORF
  } ssx_op_t;

  // Whole state of the top module
  typedef struct packed {
    logic [127:0][7:0] file_mem;
    logic [7:0]        work;
    logic              carry;
    logic              digit_carry_flag;
    logic              zero;
    logic [7:0]        port_one_direction;
    logic [7:0]        port_two_direction;
    logic [7:0]        port_three_direction;
    logic [31:0]       last_cmd;
    logic              ack;
    logic              slverr;
    logic [31:0]       rdata;
  } ssx_state_t;

endpackage

// >>> rtl/ssx_alu_if.sv
// Operand and result bundle between the top module and the arithmetic unit
`timescale 1ns/10ps
`default_nettype none

interface ssx_alu_if;
  ssx_pkg::ssx_op_t op;
  logic [7:0]       work;
  logic [7:0]       file_val;
  logic [7:0]       lit;
  logic             carry_in;
  logic [7:0]       result;
  logic             carry_out;
  logic             digit_out;
  logic             zero_out;

  modport core (output op, work, file_val, lit, carry_in, input result, carry_out, digit_out, zero_out);
  modport alu  (input op, work, file_val, lit, carry_in, output result, carry_out, digit_out, zero_out);
endinterface

`default_nettype wire

// >>> rtl/ssx_alu.sv
// Combinational result and flag generator of the datapath slice
`timescale 1ns/10ps
`default_nettype none

module ssx_alu (
  // Operands in, result and flags out
  ssx_alu_if.alu bus
);

  logic [8:0] sub_full;
  logic [4:0] sub_low;

  // Carry set means no borrow, so adding the inverted subtrahend plus carry is the subtraction
  always_comb begin
    sub_full = {1'b0, bus.file_val} + {1'b0, ~bus.work} + {8'h00, bus.carry_in};
    sub_low  = {1'b0, bus.file_val[3:0]} + {1'b0, ~bus.work[3:0]} + {4'h0, bus.carry_in};
    bus.carry_out = sub_full[8];
    bus.digit_out = sub_low[4];
    unique case (bus.op)
      ssx_pkg::SSX_OP_SUBB: bus.result = sub_full[7:0];
      ssx_pkg::SSX_OP_SWAP: bus.result = {bus.file_val[3:0], bus.file_val[7:4]};
      ssx_pkg::SSX_OP_DIR:  bus.result = bus.work;
      ssx_pkg::SSX_OP_XORI: bus.result = bus.work ^ bus.lit;
      ssx_pkg::SSX_OP_XORF: bus.result = bus.work ^ bus.file_val;
      default:              bus.result = bus.work;
    endcase
    bus.zero_out = (bus.result == 8'h00);
  end

endmodule

`default_nettype wire

// >>> rtl/ssx_datapath.sv
// APB-reached execution slice: subtract with borrow, nibble swap, XOR and direction load
`timescale 1ns/10ps
`default_nettype none
`include "ssx_regs.svh"

// How it works
// - Subtract with borrow: file minus work minus inverted carry; sets carry, digit carry, zero.
// - Destination bit 0 writes work register, 1 writes the addressed file register; XOR immediate and direction load ignore it.
// - Nibble swap exchanges file nibbles into the destination; no flag changes.
// - Direction load copies work into direction register 5, 6 or 7; flags untouched.
// - XOR immediate: work XOR literal into work; only zero flag changes.
// - XOR file: work XOR file register to destination; only zero flag changes.
module ssx_datapath (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`SSX_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Port direction registers
  output logic [7:0]                 port_one_direction,
  output logic [7:0]                 port_two_direction,
  output logic [7:0]                 port_three_direction
);

  ssx_pkg::ssx_state_t st;
  ssx_pkg::ssx_state_t next_st;
  ssx_alu_if           alu_bus ();

  logic                apb_done;
  logic                cmd_fire;
  logic [2:0]          op_code;
  logic                dest;
  logic [6:0]          faddr;
  logic [7:0]          fop;
  logic                file_hit;
  logic [6:0]          file_idx;
  logic [7:0]          wr_byte;
  logic [7:0]          swapped;
  logic [7:0]          sub_ref;
  logic                nb_ref;

  ssx_alu u_ssx_alu (
    .bus (alu_bus)
  );

  // Command decode; the command word in flight is the execute request
  assign apb_done = psel & penable & st.ack;
  assign cmd_fire = apb_done & pwrite & (paddr == `SSX_OFF_CMD);
  assign op_code  = pwdata[`SSX_CMD_OP_HI:`SSX_CMD_OP_LO];
  assign dest     = pwdata[`SSX_CMD_DEST];
  assign faddr    = pwdata[`SSX_CMD_FILE_HI:`SSX_CMD_FILE_LO];
  assign fop      = st.file_mem[faddr];
  assign file_hit = (paddr[`SSX_FILE_TAG_HI:`SSX_FILE_TAG_LO] == `SSX_FILE_TAG);
  assign file_idx = paddr[`SSX_FILE_IDX_HI:`SSX_FILE_IDX_LO];
  assign wr_byte  = pwdata[7:0];

  // Operands to the arithmetic unit
  assign alu_bus.op       = ssx_pkg::ssx_op_t'(op_code);
  assign alu_bus.work     = st.work;
  assign alu_bus.file_val = fop;
  assign alu_bus.lit      = pwdata[`SSX_CMD_LIT_HI:`SSX_CMD_LIT_LO];
  assign alu_bus.carry_in = st.carry;

  // Bus answers come from flops, so every access has exactly one setup and one access cycle
  assign pready  = psel & penable & st.ack;
  assign prdata  = st.rdata;
  assign pslverr = pready & st.slverr;

  assign port_one_direction   = st.port_one_direction;
  assign port_two_direction   = st.port_two_direction;
  assign port_three_direction = st.port_three_direction;

  // Next-state logic: bus answer capture, register writes and instruction execution
  always_comb begin
    next_st = st;
    if (psel && !penable) begin
      next_st.ack    = 1'b1;
      next_st.slverr = 1'b0;
      next_st.rdata  = 32'h0000_0000;
      if (file_hit) begin
        next_st.rdata = {24'h00_0000, st.file_mem[file_idx]};
      end else begin
        unique case (paddr)
          `SSX_OFF_CMD:    next_st.rdata = st.last_cmd;
          `SSX_OFF_WORK:   next_st.rdata = {24'h00_0000, st.work};
          `SSX_OFF_STATUS: next_st.rdata = {29'h0000_0000, st.zero, st.digit_carry_flag, st.carry};
          `SSX_OFF_DIR1:   next_st.rdata = {24'h00_0000, st.port_one_direction};
          `SSX_OFF_DIR2:   next_st.rdata = {24'h00_0000, st.port_two_direction};
          `SSX_OFF_DIR3:   next_st.rdata = {24'h00_0000, st.port_three_direction};
          default:         next_st.slverr = 1'b1; // Unmapped address answers with an error
        endcase
      end
    end
    if (apb_done) begin
      next_st.ack = 1'b0;
      if (pwrite && !st.slverr) begin
        if (file_hit) begin
          next_st.file_mem[file_idx] = wr_byte;
        end else if (paddr == `SSX_OFF_WORK) begin
          next_st.work = wr_byte;
        end else if (paddr == `SSX_OFF_STATUS) begin
          next_st.carry            = pwdata[`SSX_ST_CARRY];
          next_st.digit_carry_flag = pwdata[`SSX_ST_DIGIT];
          next_st.zero             = pwdata[`SSX_ST_ZERO];
        end else if (paddr == `SSX_OFF_CMD) begin
          next_st.last_cmd = pwdata;
        end
      end
    end
    // Illegal op codes are stored in the command register but execute nothing
    if (cmd_fire) begin
      unique case (op_code)
        3'(ssx_pkg::SSX_OP_SUBB): begin
          next_st.carry            = alu_bus.carry_out;
          next_st.digit_carry_flag = alu_bus.digit_out;
          next_st.zero             = alu_bus.zero_out;
          if (dest == `SSX_DEST_FILE) begin
            next_st.file_mem[faddr] = alu_bus.result;
          end else begin
            next_st.work = alu_bus.result;
          end
        end
        3'(ssx_pkg::SSX_OP_SWAP), 3'(ssx_pkg::SSX_OP_XORF): begin
          if (op_code == 3'(ssx_pkg::SSX_OP_XORF)) begin
            next_st.zero = alu_bus.zero_out;
          end
          if (dest == `SSX_DEST_FILE) begin
            next_st.file_mem[faddr] = alu_bus.result;
          end else begin
            next_st.work = alu_bus.result;
          end
        end
        3'(ssx_pkg::SSX_OP_DIR): begin
          // Operands outside 5..7 select no direction register
          if (faddr == `SSX_DIR_OP1) next_st.port_one_direction = st.work;
          if (faddr == `SSX_DIR_OP2) next_st.port_two_direction = st.work;
          if (faddr == `SSX_DIR_OP3) next_st.port_three_direction = st.work;
        end
        3'(ssx_pkg::SSX_OP_XORI): begin
          next_st.work = alu_bus.result;
          next_st.zero = alu_bus.zero_out;
        end
        default: begin
          next_st.last_cmd = pwdata;
        end
      endcase
    end
  end

  // State register; file array is cleared at reset so reads are never unknown
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st                      <= '0;
      st.port_one_direction   <= `SSX_DIR_RESET;
      st.port_two_direction   <= `SSX_DIR_RESET;
      st.port_three_direction <= `SSX_DIR_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Reference values for the checks, built independently of the arithmetic unit
  assign swapped = {fop[3:0], fop[7:4]};
  assign sub_ref = 8'(fop - st.work - {7'h00, ~st.carry});
  assign nb_ref  = ({1'b0, fop} >= ({1'b0, st.work} + {8'h00, ~st.carry}));

  a_subb_value: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && op_code == 3'(ssx_pkg::SSX_OP_SUBB) && !dest |=> st.work == $past(sub_ref))
    else $error("subtract result wrong");

  a_subb_borrow: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && op_code == 3'(ssx_pkg::SSX_OP_SUBB)
    |=> st.carry == $past(nb_ref) && st.zero == ($past(sub_ref) == 8'h00))
    else $error("subtract carry or zero wrong");

  a_dest_file: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && dest && op_code != 3'(ssx_pkg::SSX_OP_XORI) && op_code != 3'(ssx_pkg::SSX_OP_DIR)
    |=> st.work == $past(st.work))
    else $error("file destination touched work register");

  a_swap_nibbles: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && op_code == 3'(ssx_pkg::SSX_OP_SWAP)
    |=> ($past(dest) ? st.file_mem[$past(faddr)] : st.work) == $past(swapped)
        && {st.carry, st.digit_carry_flag, st.zero} == $past({st.carry, st.digit_carry_flag, st.zero}))
    else $error("nibble swap wrong or flags changed");

  a_dir_load: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && op_code == 3'(ssx_pkg::SSX_OP_DIR) && faddr == `SSX_DIR_OP2
    |=> port_two_direction == $past(st.work) && st.zero == $past(st.zero) ##1 port_two_direction == $past(st.work, 2))
    else $error("direction load wrong");

  a_xori_value: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && op_code == 3'(ssx_pkg::SSX_OP_XORI)
    |=> st.work == ($past(st.work) ^ $past(alu_bus.lit)) && st.carry == $past(st.carry)
        && st.zero == (st.work == 8'h00))
    else $error("xor immediate wrong");

  a_xorf_flags: assert property (@(posedge clk) disable iff (!arst_n)
    cmd_fire && op_code == 3'(ssx_pkg::SSX_OP_XORF) && !dest
    |=> st.work == ($past(st.work) ^ $past(fop)) && st.digit_carry_flag == $past(st.digit_carry_flag))
    else $error("xor file wrong");

  a_apb_answer: assert property (@(posedge clk) disable iff (!arst_n)
    psel && !penable ##1 psel && penable |-> pready)
    else $error("access phase not answered at once");

endmodule

`default_nettype wire

// >>> sim/ssx_datapath_bench.sv
// Self-checking bench of the datapath slice: corner and random instruction runs over APB
`timescale 1ns/10ps
`default_nettype none
`include "ssx_regs.svh"

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module ssx_datapath_bench;
  logic                   clk;
  logic                   arst_n;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic                   pready;
  logic                   pslverr;
  logic [`SSX_ADDR_W-1:0] paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic [31:0]            rdat;
  logic                   err;
  logic [7:0]             dir1;
  logic [7:0]             dir2;
  logic [7:0]             dir3;
  int                     num_errors;
  int                     num_checks;
  // Reference copy of the slice state, updated from the instruction semantics
  logic [7:0]             m_work;
  logic [7:0]             m_file [128];
  logic [7:0]             m_dir [3];
  logic                   m_c;
  logic                   m_dc;
  logic                   m_z;
  logic [2:0]             r_op;
  logic [6:0]             r_fa;

  ssx_datapath u_ssx_datapath (
    .clk                  (clk),
    .arst_n               (arst_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pready               (pready),
    .prdata               (prdata),
    .pslverr              (pslverr),
    .port_one_direction   (dir1),
    .port_two_direction   (dir2),
    .port_three_direction (dir3)
  );

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // One APB transfer; an idle edge first so no strobe is assigned twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat    = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] mkcmd(input logic [2:0] op, input logic dst, input logic [6:0] fa,
                                        input logic [7:0] k);
    return {8'h00, k, 5'h00, fa, dst, op};
  endfunction

  // Expected effect of one command on the reference state
  task automatic model_exec(input logic [31:0] cmd);
    logic [6:0] fa;
    logic [7:0] f;
    logic [7:0] r;
    logic [8:0] t;
    logic [4:0] lo;
    fa = cmd[10:4];
    f  = m_file[fa];
    r  = 8'h00;
    case (cmd[2:0])
      3'h0: begin
        t    = {1'b0, f} - {1'b0, m_work} - {8'h00, ~m_c};
        lo   = {1'b0, f[3:0]} - {1'b0, m_work[3:0]} - {4'h0, ~m_c};
        r    = t[7:0];
        m_c  = ~t[8];
        m_dc = ~lo[4];
      end
      3'h1: r = {f[3:0], f[7:4]};
      3'h2: if (fa >= 7'h05 && fa <= 7'h07) m_dir[int'(fa) - 5] = m_work;
      3'h3: r = m_work ^ cmd[23:16];
      3'h4: r = m_work ^ f;
      default: ;
    endcase
    if (cmd[2:0] == 3'h0 || cmd[2:0] == 3'h3 || cmd[2:0] == 3'h4) m_z = (r == 8'h00);
    if (cmd[2:0] == 3'h3) m_work = r;
    else if (cmd[2:0] <= 3'h1 || cmd[2:0] == 3'h4) begin
      if (cmd[3]) m_file[fa] = r;
      else m_work = r;
    end
  endtask

  // Read back everything the command may have touched
  task automatic check_state(input logic [6:0] fa);
    apb(1'b0, `SSX_OFF_WORK, 32'h0);
    `CHK(rdat, {24'h0, m_work})
    apb(1'b0, `SSX_OFF_STATUS, 32'h0);
    `CHK(rdat, {29'h0, m_z, m_dc, m_c})
    apb(1'b0, 12'h200 + {3'h0, fa, 2'h0}, 32'h0);
    `CHK(rdat, {24'h0, m_file[fa]})
    apb(1'b0, `SSX_OFF_DIR3, 32'h0);
    `CHK(rdat, {24'h0, m_dir[2]})
    `CHK({dir1, dir2, dir3}, {m_dir[0], m_dir[1], m_dir[2]})
  endtask

  // Preload operands, execute one command, compare
  task automatic run(input logic [7:0] w, input logic [2:0] st, input logic [7:0] fv, input logic [31:0] cmd);
    apb(1'b1, `SSX_OFF_WORK, {24'h0, w});
    apb(1'b1, `SSX_OFF_STATUS, {29'h0, st});
    apb(1'b1, 12'h200 + {3'h0, cmd[10:4], 2'h0}, {24'h0, fv});
    apb(1'b1, `SSX_OFF_CMD, cmd);
    m_work           = w;
    {m_z, m_dc, m_c} = st;
    m_file[cmd[10:4]] = fv;
    model_exec(cmd);
    check_state(cmd[10:4]);
    // The command register keeps the last word written, illegal op codes included
    apb(1'b0, `SSX_OFF_CMD, 32'h0);
    `CHK(rdat, cmd)
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the roughly 4400 cycles the tests need
  initial begin
    #300000;
    num_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    arst_n     = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = '0;
    pwdata     = 32'h0;
    num_errors = 0;
    num_checks = 0;
    m_work     = 8'h00;
    {m_z, m_dc, m_c} = 3'h0;
    foreach (m_file[i]) m_file[i] = 8'h00;
    foreach (m_dir[i]) m_dir[i] = `SSX_DIR_RESET;
    void'($urandom(99840));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    check_state(7'h7f);
    apb(1'b0, 12'h018, 32'h0);
    `CHK({err, rdat}, {1'b1, 32'h0})
    apb(1'b1, `SSX_OFF_DIR1, 32'h0);
    check_state(7'h00);
    $display("test reset_and_map done");
    // Borrow boundaries, zero results, flag-free ops, every direction operand and an illegal op
    run(8'h10, 3'h0, 8'h10, mkcmd(3'h0, 1'b0, 7'h11, 8'h00));
    run(8'h01, 3'h1, 8'h10, mkcmd(3'h0, 1'b1, 7'h22, 8'h00));
    run(8'h00, 3'h1, 8'h00, mkcmd(3'h0, 1'b1, 7'h7f, 8'h00));
    run(8'h5a, 3'h7, 8'ha5, mkcmd(3'h1, 1'b1, 7'h30, 8'h00));
    run(8'h5a, 3'h0, 8'hc3, mkcmd(3'h1, 1'b0, 7'h31, 8'h00));
    for (int i = 4; i < 8; i++) run(8'(i * 17), 3'h7, 8'h00, mkcmd(3'h2, 1'b0, 7'(i), 8'h00));
    run(8'h3c, 3'h3, 8'h00, mkcmd(3'h3, 1'b1, 7'h01, 8'h3c));
    run(8'h99, 3'h3, 8'h99, mkcmd(3'h4, 1'b1, 7'h40, 8'h00));
    run(8'h77, 3'h5, 8'h12, mkcmd(3'h7, 1'b1, 7'h41, 8'hff));
    $display("test corner_cases done");
    // Random commands, direction operands drawn near 5..7 so all hit often
    repeat (150) begin
      r_op = 3'($urandom % 8);
      r_fa = (r_op == 3'h2) ? 7'(3 + $urandom % 6) : 7'($urandom);
      run(8'($urandom), 3'($urandom), 8'($urandom), mkcmd(r_op, 1'($urandom), r_fa, 8'($urandom)));
    end
    $display("test random_commands done");
    // Reset in mid-run: directions, work, flags and file array return to their reset values
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    m_work           = 8'h00;
    {m_z, m_dc, m_c} = 3'h0;
    foreach (m_file[i]) m_file[i] = 8'h00;
    foreach (m_dir[i]) m_dir[i] = `SSX_DIR_RESET;
    check_state(r_fa);
    $display("test mid_reset done");
    tally_and_finish();
  end
endmodule

`default_nettype wire
